/* File: bit_field_extract_insert.sv */
// Function
// - extract: field right-justified, zeros above
// - extract: size-1 at 15..11, pos at 10..6
// - extract: 32-bit word sign-extended to 64
// - insert: low source bits replace field
// - insert: top at 15..11, bottom at 10..6
// - insert: merged word sign-extended to 64
// - release one: reserved-instruction exception
`timescale 1ns/1ps
`default_nettype none

module bit_field_extract_insert (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic issue_i,
	input wire logic [31:0] instr_i,
	input wire logic release_two_i,
	input wire logic [63:0] source_value_i,
	input wire logic [63:0] target_value_i,
	output logic [4:0] source_register_specifier_o,
	output logic [4:0] target_register_specifier_o,
	output logic [63:0] result_o,
	output logic [4:0] dest_register_o,
	output logic result_valid_o,
	output logic reserved_instr_o
);

	// ======================================================
	// decode
	function automatic bitfield_pkg::bf_op_e decode_op(input logic [31:0] ins);
		bitfield_pkg::bf_op_e op;
		op = bitfield_pkg::OP_NONE;
		if (ins[bitfield_pkg::OPC_HI:bitfield_pkg::OPC_LO] ==
			bitfield_pkg::THIRD_SPECIAL_MAJOR_OPCODE) begin
			if (ins[bitfield_pkg::FN_HI:bitfield_pkg::FN_LO] == bitfield_pkg::FN_EXTRACT) begin
				op = bitfield_pkg::OP_EXTRACT;
			end else if (ins[bitfield_pkg::FN_HI:bitfield_pkg::FN_LO] ==
				bitfield_pkg::FN_INSERT) begin
				op = bitfield_pkg::OP_INSERT;
			end
		end
		return op;
	endfunction

	wire bitfield_pkg::bf_op_e op;
	wire logic is_bitfield;
	wire logic [4:0] top_idx;
	wire logic [4:0] bot_idx;

	assign op = decode_op(instr_i);
	assign is_bitfield = (op != bitfield_pkg::OP_NONE);
	assign source_register_specifier_o = instr_i[bitfield_pkg::SRC_HI:bitfield_pkg::SRC_LO];
	assign target_register_specifier_o = instr_i[bitfield_pkg::TGT_HI:bitfield_pkg::TGT_LO];
	assign top_idx = instr_i[bitfield_pkg::TOP_HI:bitfield_pkg::TOP_LO];
	assign bot_idx = instr_i[bitfield_pkg::BOT_HI:bitfield_pkg::BOT_LO];

	// ======================================================
	// extract path
	// out-of-range pos plus size gives a don't-care word, not a trap
	wire logic [31:0] ext_mask;
	wire logic [31:0] ext_shifted;
	wire logic [31:0] ext_word;

	bitfield_mask u_ext_mask (
		.hi_i(top_idx),
		.lo_i(5'd0),
		.mask_o(ext_mask)
	);

	assign ext_shifted = source_value_i[31:0] >> bot_idx;
	assign ext_word = ext_shifted & ext_mask;

	// ======================================================
	// insert path
	// bottom above top yields an empty mask: target passes through
	wire logic [31:0] ins_mask;
	wire logic [31:0] ins_src;
	wire logic [31:0] ins_word;

	bitfield_mask u_ins_mask (
		.hi_i(top_idx),
		.lo_i(bot_idx),
		.mask_o(ins_mask)
	);

	assign ins_src = source_value_i[31:0] << bot_idx;
	assign ins_word = (target_value_i[31:0] & ~ins_mask) | (ins_src & ins_mask);

	// ======================================================
	// result select
	// upper operand bits ignored; only bit 31 of the word matters
	wire logic [31:0] sel_word;
	wire logic [63:0] sel_result;
	wire logic take;
	wire logic reject;

	assign sel_word = (op == bitfield_pkg::OP_INSERT) ? ins_word : ext_word;
	assign sel_result = {{(bitfield_pkg::DWORD_W - bitfield_pkg::WORD_W){sel_word[31]}},
		sel_word};
	assign take = issue_i & is_bitfield & release_two_i;
	assign reject = issue_i & is_bitfield & ~release_two_i;

	// ======================================================
	// output registers
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_o <= bitfield_pkg::RESULT_RST;
			dest_register_o <= bitfield_pkg::SPEC_RST;
			result_valid_o <= 1'b0;
			reserved_instr_o <= 1'b0;
		end else begin
			result_valid_o <= take;
			reserved_instr_o <= reject;
			if (take) begin
				result_o <= sel_result;
				dest_register_o <= target_register_specifier_o;
			end
		end
	end

endmodule

`default_nettype wire

/* File: bitfield_pkg.sv */
package bitfield_pkg;

	// ======================================================
	// instruction field positions
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int SRC_HI = 25;
	localparam int SRC_LO = 21;
	localparam int TGT_HI = 20;
	localparam int TGT_LO = 16;
	localparam int TOP_HI = 15;
	localparam int TOP_LO = 11;
	localparam int BOT_HI = 10;
	localparam int BOT_LO = 6;
	localparam int FN_HI = 5;
	localparam int FN_LO = 0;

	// ======================================================
	// encodings
	localparam logic [5:0] THIRD_SPECIAL_MAJOR_OPCODE = 6'h1F;
	localparam logic [5:0] FN_EXTRACT = 6'h00;
	localparam logic [5:0] FN_INSERT = 6'h04;

	// ======================================================
	// widths and reset values
	localparam int WORD_W = 32;
	localparam int DWORD_W = 64;
	localparam logic [63:0] RESULT_RST = 64'h0;
	localparam logic [4:0] SPEC_RST = 5'h0;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_EXTRACT,
		OP_INSERT
	} bf_op_e;

endpackage

/* File: bitfield_mask.sv */
`timescale 1ns/1ps
`default_nettype none

// ======================================================
// contiguous ones from bit lo up to bit hi
module bitfield_mask (
	input wire logic [4:0] hi_i,
	input wire logic [4:0] lo_i,
	output logic [31:0] mask_o
);

	wire logic [31:0] upto_hi;
	wire logic [31:0] from_lo;

	// two shifts avoid a variable-width slice
	assign upto_hi = 32'hFFFFFFFF >> (5'd31 - hi_i);
	assign from_lo = 32'hFFFFFFFF << lo_i;
	assign mask_o = upto_hi & from_lo;

endmodule

`default_nettype wire

/* File: bfx_regfile.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// register file model: word values only
module bfx_regfile (
	input wire logic [4:0] spec_i,
	output logic [63:0] value_o
);
	wire logic [31:0] v = {spec_i, 27'h5A3C9E1} ^ {27'h0, spec_i};
	assign value_o = {{32{v[31]}}, v};
endmodule
`default_nettype wire

/* File: bfx_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// checker, sees top ports only
module bfx_monitor (
	input wire logic core_clk_i, rst_i, issue_i, release_two_i,
	input wire logic [31:0] instr_i,
	input wire logic [63:0] source_value_i, result_o,
	input wire logic [4:0] source_register_specifier_o, dest_register_o,
	input wire logic result_valid_o, reserved_instr_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	wire logic bf = issue_i && instr_i[31:26] == 6'h1F && (instr_i[5:0] & 6'h3B) == 6'h0;
	wire logic go = bf && release_two_i;
	wire logic s0 = source_value_i[0], sel = source_value_i[instr_i[10:6]];
	wire logic [4:0] tg = instr_i[20:16], lo = instr_i[10:6];
	wire logic [5:0] wd = instr_i[15:11] + 6'h1;
	sequence ext_s; go && !instr_i[2]; endsequence
	chk_spec_map: assert property (source_register_specifier_o == instr_i[25:21])
		else $error("bad specifier");
	chk_exec_pulse: assert property (go |=> result_valid_o && dest_register_o == $past(tg))
		else $error("no result");
	chk_refuse: assert property (bf && !release_two_i |=> reserved_instr_o && !result_valid_o)
		else $error("no refusal");
	chk_quiet_hold: assert property (!go |=> !result_valid_o && $stable(result_o))
		else $error("spurious result");
	chk_sign_ext: assert property (result_valid_o |-> result_o[63:32] == {32{result_o[31]}})
		else $error("not sign-extended");
	chk_ext_low: assert property (ext_s |=> result_o[0] == $past(sel))
		else $error("bad low bit");
	chk_ext_zero: assert property (ext_s |=> (result_o[31:0] >> $past(wd)) == 32'h0)
		else $error("bits above field");
	chk_ins_low: assert property (go && instr_i[2] |=> result_o[$past(lo)] == $past(s0))
		else $error("bad insert");
endmodule
bind bit_field_extract_insert bfx_monitor bfx_monitor_i (.*);
`default_nettype wire

/* File: bit_field_extract_insert_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_field_extract_insert_tb;
	logic core_clk_i = 1'h0, rst_i = 1'h1, issue_i = 1'h0, release_two_i = 1'h1;
	logic [31:0] instr_i = 32'h0, w;
	logic [63:0] s, t, m;
	wire logic [4:0] source_register_specifier_o, target_register_specifier_o, dest_register_o;
	wire logic [63:0] source_value_i, target_value_i, result_o;
	wire logic result_valid_o, reserved_instr_o;
	int errors = 0, total_checks = 0;
	always #5 core_clk_i = ~core_clk_i;
	bit_field_extract_insert bit_field_extract_insert_i (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.issue_i(issue_i),
		.instr_i(instr_i),
		.release_two_i(release_two_i),
		.source_value_i(source_value_i),
		.target_value_i(target_value_i),
		.source_register_specifier_o(source_register_specifier_o),
		.target_register_specifier_o(target_register_specifier_o),
		.result_o(result_o),
		.dest_register_o(dest_register_o),
		.result_valid_o(result_valid_o),
		.reserved_instr_o(reserved_instr_o)
	);
	bfx_regfile src_rf (.spec_i(source_register_specifier_o), .value_o(source_value_i));
	bfx_regfile tgt_rf (.spec_i(target_register_specifier_o), .value_o(target_value_i));
	task print_verdict;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic ok);
		total_checks++;
		if (ok !== 1'h1) begin
			errors++;
			$display("CHECK FAILED %0t bad output", $time);
		end
	endtask
	// ==========
	// operands copied once decode settles
	task run(input logic [5:0] fn, input logic [4:0] rs, hi, lo, input logic rel);
		@(negedge core_clk_i);
		instr_i = {6'h1F, rs, rs + 5'h8, hi, lo, fn};
		issue_i = 1'h1;
		release_two_i = rel;
		#1 {s, t} = {source_value_i, target_value_i};
		@(negedge core_clk_i);
		issue_i = 1'h0;
	endtask
	task test_fields;
		for (int i = 0; i < 14; i++) begin
			int p, n;
			p = i % 7 * 5;
			n = i < 7 ? 32 - p : 1;
			m = (64'h1 << n) - 64'h1;
			run(6'h00, i[4:0], 5'(n - 1), 5'(p), 1'h1);
			w = s[31:0] >> p & m[31:0];
			chk(result_o === {{32{w[31]}}, w} && dest_register_o === 5'(i + 8));
			m = m << p;
			run(6'h04, i[4:0], 5'(p + n - 1), 5'(p), 1'h1);
			w = t[31:0] & ~m[31:0] | s[31:0] << p & m[31:0];
			chk(result_valid_o && result_o === {{32{w[31]}}, w});
		end
		// negative source word: full-width field must carry the sign up
		run(6'h00, 5'h11, 5'h1F, 5'h00, 1'h1);
		w = s[31:0];
		chk(result_valid_o && w[31] && result_o === {{32{w[31]}}, w});
		chk(source_register_specifier_o === 5'h11 && target_register_specifier_o === 5'h19);
		$display("fields done");
	endtask
	task test_refused;
		run(6'h04, 5'h3, 5'h9, 5'h2, 1'h0);
		chk(reserved_instr_o && !result_valid_o && result_o === {{32{w[31]}}, w});
		run(6'h01, 5'h3, 5'h9, 5'h2, 1'h1);
		chk(!reserved_instr_o && !result_valid_o && result_o === {{32{w[31]}}, w});
		$display("refused done");
	endtask
	initial begin
		#20000 errors++;
		print_verdict;
	end
	initial begin
		repeat (16) @(posedge core_clk_i);
		@(negedge core_clk_i) rst_i = 1'h0;
		test_fields;
		test_refused;
		print_verdict;
	end
endmodule
`default_nettype wire
